// ---- guard_monitor_pkg.sv ----
// constants and types shared by the guard input monitor
`default_nettype none
package guard_monitor_pkg;
  // system clock rate
  localparam int CLOCK_HZ = 10_000_000;
  // closed-to-open debounce in milliseconds and in cycles
  localparam int DEBOUNCE_MS = 6;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MS * CLOCK_HZ + 999) / 1000;
  // open-to-closed filter, short, in cycles
  localparam int CLOSE_FILTER_CYCLES = 16;
  // both-open time before the cross-short check, seconds and cycles
  localparam int CROSS_OPEN_S = 2;
  localparam int CROSS_OPEN_CYCLES = CROSS_OPEN_S * CLOCK_HZ + 1;
  // test pulse period and low width in cycles
  localparam int PULSE_PERIOD_CYCLES = 1000;
  localparam int PULSE_WIDTH_CYCLES = 5;
  // values after reset
  localparam logic SEEN_RESET = 1'b1;
  localparam logic [1:0] OUTPUTS_RESET = 2'b00;
  // wiring options of the input pair
  typedef enum logic [3:0] {
    single_1t, single_2t, single_pnp, dual_2t, dual_3t, dual_pnp, dual_4t,
    compl_2t, compl_pnp, compl_x2
  } wiring_t;
  // supervisor states
  typedef enum logic {st_stop, st_run} guard_state_t;
endpackage
`default_nettype wire

// ---- contact_debounce.sv ----
// asymmetric debounce of one contact channel
`timescale 1ns/1ns
`default_nettype none
module contact_debounce #(
  parameter int OPEN_CYCLES = 60000,
  parameter int CLOSE_CYCLES = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // raw level in, filtered level out (1 = conducting)
  input wire logic raw,
  output logic stable
);
  localparam int CW = $clog2(OPEN_CYCLES + CLOSE_CYCLES + 1);
  localparam logic [CW-1:0] OPEN_LAST = CW'(OPEN_CYCLES - 1);
  localparam logic [CW-1:0] CLOSE_LAST = CW'(CLOSE_CYCLES - 1);
  logic [CW-1:0] count; // cycles the raw level has differed
  logic [CW-1:0] next_count;
  logic next_stable;
  // count a differing level; flip once it held long enough
  always_comb begin
    next_count = '0;
    next_stable = stable;
    if (raw != stable) begin
      if ((stable && count == OPEN_LAST) || (!stable && count == CLOSE_LAST)) begin
        next_stable = raw;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end
  // register the filter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      stable <= 1'b0;
    end else begin
      count <= next_count;
      stable <= next_stable;
    end
  end
endmodule // contact_debounce
`default_nettype wire

// ---- guard_input_monitor.sv ----
// dual channel guard input monitor with latched fault handling
`timescale 1ns/1ns
`default_nettype none
module guard_input_monitor
  import guard_monitor_pkg::*;
#(
  parameter int DEBOUNCE = DEBOUNCE_CYCLES,
  parameter int CROSS_OPEN = CROSS_OPEN_CYCLES,
  parameter int PULSE_PERIOD = PULSE_PERIOD_CYCLES,
  parameter int PULSE_WIDTH = PULSE_WIDTH_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // contact inputs, 1 = conducting
  input wire logic contact_a,
  input wire logic contact_b,
  // configuration and reset request
  input wire wiring_t wiring,
  input wire logic reset_req,
  // test pulse drives, low during a test
  output logic test_pulse_a,
  output logic test_pulse_b,
  // safety outputs and status
  output logic [1:0] safety_output_pair,
  output logic reset_blocked,
  output logic discrepancy_fault,
  output logic power_short_fault,
  output logic cross_short_fault,
  output logic complement_fault,
  output logic short_detect_active
);
  localparam int PCW = $clog2(PULSE_PERIOD);
  localparam int OCW = $clog2(CROSS_OPEN + 1);
  localparam logic [PCW-1:0] P_LAST = PCW'(PULSE_PERIOD - 1);
  localparam logic [PCW-1:0] P_WIDTH = PCW'(PULSE_WIDTH);
  localparam logic [PCW-1:0] P_HALF = PCW'(PULSE_PERIOD / 2);
  localparam logic [OCW-1:0] O_LIMIT = OCW'(CROSS_OPEN);
  localparam int PW_CHK = PULSE_WIDTH;
  localparam int PW_NEXT = PULSE_WIDTH + 1;
  // agreement timer of the complementary pair, sized for the debounce time
  localparam int CCW = $clog2(DEBOUNCE + 1);
  localparam logic [CCW-1:0] C_LIMIT = CCW'(DEBOUNCE);

  logic [1:0] raw; // raw contacts
  logic [1:0] db; // debounced contacts
  assign raw = {contact_b, contact_a};
  // one filter per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_deb
      contact_debounce #(.OPEN_CYCLES(DEBOUNCE), .CLOSE_CYCLES(CLOSE_FILTER_CYCLES)) u_deb (
        .clock(clock), .rst_n(rst_n), .raw(raw[ch]), .stable(db[ch]));
    end
  endgenerate

  // wiring classes
  logic single, compl, pulsed, power_chk, cross_mode;
  assign single = (wiring == single_1t) || (wiring == single_2t) || (wiring == single_pnp);
  assign compl = (wiring == compl_2t) || (wiring == compl_pnp) || (wiring == compl_x2);
  assign power_chk = (wiring == single_2t) || (wiring == dual_3t) || (wiring == dual_4t);
  assign pulsed = power_chk || (wiring == dual_2t);
  // per channel guard-closed reading; complementary wants first open, second closed
  logic ok_a, ok_b, guard_closed;
  assign ok_a = compl ? !db[0] : db[0];
  assign ok_b = single ? 1'b1 : db[1];
  assign guard_closed = ok_a && ok_b;

  // registered state
  guard_state_t state, next_state;
  logic seen_a, seen_b, next_seen_a, next_seen_b; // channel opened since last reset acceptance or fault
  logic closed_prev, next_closed_prev;
  logic [OCW-1:0] open_cnt, next_open_cnt; // both-open duration
  logic [CCW-1:0] same_cnt, next_same_cnt; // cycles the complementary pair agrees
  logic [PCW-1:0] pulse_cnt, next_pulse_cnt;
  logic next_disc, next_power, next_cross, next_compl;
  logic next_pulse_a, next_pulse_b, next_blocked, next_active;
  logic [1:0] next_outputs;
  // event terms
  logic end_a, end_b, ev_power, ev_cross, ev_compl, ev_disc, accept, any_fault;
  assign cross_mode = (wiring == dual_4t) ||
    (((wiring == dual_2t) || (wiring == dual_3t)) && open_cnt == O_LIMIT);
  // last low cycle of each test pulse
  assign end_a = !test_pulse_a && pulse_cnt == P_WIDTH - 1'b1;
  assign end_b = !test_pulse_b && pulse_cnt == P_HALF + P_WIDTH - 1'b1;
  // a closed contact still conducting at pulse end means a foreign supply
  assign ev_power = power_chk && ((end_a && db[0] && contact_a) ||
    (!single && end_b && db[1] && contact_b));
  // both lines high while only one is pulsed low means they are joined
  assign ev_cross = cross_mode && contact_a && contact_b && (test_pulse_a != test_pulse_b);
  // equal levels must outlast the debounce time, so a normal changeover never trips
  assign ev_compl = compl && (db[0] == db[1]) && same_cnt == C_LIMIT;
  // closing again without both channels having opened
  assign ev_disc = !single && state == st_stop && guard_closed && !closed_prev &&
    !(seen_a && seen_b);
  assign any_fault = ev_power || ev_cross || ev_compl || ev_disc;
  assign accept = state == st_stop && reset_req && guard_closed && seen_a && seen_b &&
    !any_fault;

  // next-state logic of the supervisor, fault latches and test pulses
  always_comb begin
    next_state = state;
    next_seen_a = seen_a || !ok_a;
    next_seen_b = single || seen_b || !ok_b;
    next_closed_prev = guard_closed;
    // faults stick; a new event wins over the clear at reset acceptance
    next_disc = (discrepancy_fault && !accept) || ev_disc;
    next_power = (power_short_fault && !accept) || ev_power;
    next_cross = (cross_short_fault && !accept) || ev_cross;
    next_compl = (complement_fault && !accept) || ev_compl;
    // both-open timer, saturating
    if (!single && !ok_a && !ok_b) begin
      next_open_cnt = (open_cnt == O_LIMIT) ? open_cnt : open_cnt + 1'b1;
    end else begin
      next_open_cnt = '0;
    end
    // complementary agreement timer, saturating; cleared when the levels differ
    if (compl && db[0] == db[1]) begin
      next_same_cnt = (same_cnt == C_LIMIT) ? same_cnt : same_cnt + 1'b1;
    end else begin
      next_same_cnt = '0;
    end
    // free running pulse phase
    next_pulse_cnt = (pulse_cnt == P_LAST) ? '0 : pulse_cnt + 1'b1;
    unique case (state)
      // any open channel or fault stops at once
      st_run: begin
        if (!guard_closed || any_fault) begin
          next_state = st_stop;
        end
      end
      // stay off until cycled and asked
      st_stop: begin
        if (accept) begin
          next_state = st_run;
        end
      end
    endcase
    // a fault demands a fresh open-close of both channels
    if (any_fault || accept) begin
      next_seen_a = 1'b0;
      next_seen_b = single;
    end
    // outputs follow the coming state
    next_outputs = (next_state == st_run) ? 2'b11 : 2'b00;
    next_blocked = !(next_seen_a && next_seen_b);
    // staggered low pulses on the channels that are pulse tested
    next_pulse_a = !(pulsed && next_pulse_cnt < P_WIDTH);
    next_pulse_b = !(pulsed && !single && next_pulse_cnt >= P_HALF &&
      next_pulse_cnt < P_HALF + P_WIDTH);
    // power-short detection claimed only where it exists
    next_active = power_chk;
  end

  // register everything
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_stop;
      seen_a <= SEEN_RESET;
      seen_b <= SEEN_RESET;
      closed_prev <= 1'b0;
      open_cnt <= '0;
      same_cnt <= '0;
      // last phase, so the first pulse after reset has its full width
      pulse_cnt <= P_LAST;
      discrepancy_fault <= 1'b0;
      power_short_fault <= 1'b0;
      cross_short_fault <= 1'b0;
      complement_fault <= 1'b0;
      safety_output_pair <= OUTPUTS_RESET;
      reset_blocked <= 1'b0;
      test_pulse_a <= 1'b1;
      test_pulse_b <= 1'b1;
      short_detect_active <= 1'b0;
    end else begin
      state <= next_state;
      seen_a <= next_seen_a;
      seen_b <= next_seen_b;
      closed_prev <= next_closed_prev;
      open_cnt <= next_open_cnt;
      same_cnt <= next_same_cnt;
      pulse_cnt <= next_pulse_cnt;
      discrepancy_fault <= next_disc;
      power_short_fault <= next_power;
      cross_short_fault <= next_cross;
      complement_fault <= next_compl;
      safety_output_pair <= next_outputs;
      reset_blocked <= next_blocked;
      test_pulse_a <= next_pulse_a;
      test_pulse_b <= next_pulse_b;
      short_detect_active <= next_active;
    end
  end

  // checks beside the logic
  a_open_stops: assert property (@(posedge clock) disable iff (!rst_n)
    !guard_closed |=> safety_output_pair == 2'b00) else $error("outputs on with channel open");
  a_uncycled_off: assert property (@(posedge clock) disable iff (!rst_n)
    (state == st_stop && !(seen_a && seen_b)) |=> safety_output_pair == 2'b00)
    else $error("outputs on without full cycle");
  a_cycle_reset: assert property (@(posedge clock) disable iff (!rst_n)
    (state == st_stop && reset_req && guard_closed && seen_a && seen_b && !any_fault)
    |=> safety_output_pair == 2'b11 && !discrepancy_fault) else $error("cycled reset refused");
  a_disc_latch: assert property (@(posedge clock) disable iff (!rst_n)
    ev_disc |=> discrepancy_fault && reset_blocked) else $error("discrepancy not latched");
  a_fault_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (power_short_fault && !accept) |=> power_short_fault) else $error("fault dropped early");
  a_pulse_low: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(test_pulse_a) |-> !test_pulse_a [*5] ##1 test_pulse_a or PW_CHK != 5)
    else $error("pulse width wrong");
  a_pulse_back: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(test_pulse_a) |-> ##[1:PW_NEXT] test_pulse_a) else $error("pulse never ends");
  a_power_short: assert property (@(posedge clock) disable iff (!rst_n)
    (power_chk && end_a && db[0] && contact_a) |=> power_short_fault && !safety_output_pair[0])
    else $error("power short missed");
  a_no_claim: assert property (@(posedge clock) disable iff (!rst_n)
    (wiring == single_1t || wiring == single_pnp || wiring == dual_pnp) |=>
    !short_detect_active && !power_short_fault || $past(power_short_fault))
    else $error("detection claimed");
  a_cross_open: assert property (@(posedge clock) disable iff (!rst_n)
    (wiring == dual_2t && open_cnt != O_LIMIT && !cross_short_fault) |=> !cross_short_fault)
    else $error("cross check too early");
  a_compl_same: assert property (@(posedge clock) disable iff (!rst_n)
    (compl && db[0] == db[1] && same_cnt == C_LIMIT) |=>
    complement_fault && safety_output_pair == 2'b00)
    else $error("complement fault missed");
  a_compl_early: assert property (@(posedge clock) disable iff (!rst_n)
    (!complement_fault && same_cnt != C_LIMIT) |=> !complement_fault)
    else $error("complement fault too early");
  c_run: cover property (@(posedge clock) disable iff (!rst_n) $rose(safety_output_pair[0]));
  c_disc: cover property (@(posedge clock) disable iff (!rst_n) $rose(discrepancy_fault));
  c_power: cover property (@(posedge clock) disable iff (!rst_n) $rose(power_short_fault));
  c_cross: cover property (@(posedge clock) disable iff (!rst_n) $rose(cross_short_fault));
endmodule // guard_input_monitor
`default_nettype wire

// ---- guard_switch_model.sv ----
// guard switch contacts with fault injection, as seen by the monitor
`timescale 1ns/1ns
`default_nettype none
module guard_switch_model (
  // pulse drives from the monitor
  input wire logic test_pulse_a,
  input wire logic test_pulse_b,
  // actuator and fault controls
  input wire logic open_a,
  input wire logic open_b,
  input wire logic compl,
  input wire logic short_pwr,
  input wire logic short_cross,
  // contact levels, 1 = conducting
  output logic contact_a,
  output logic contact_b
);
  logic a_src; // level passed through contact a
  logic b_src; // level passed through contact b
  // a closed contact passes its pulse drive; an open one reads low, never a held value
  always_comb begin
    // complementary wiring turns contact a round: open while the guard is shut
    a_src = (compl ? open_a : ~open_a) & test_pulse_a;
    b_src = ~open_b & test_pulse_b;
    // a power short pins line a high; a cross short ties the two lines together
    contact_a = a_src | short_pwr | (short_cross & b_src);
    contact_b = b_src | (short_cross & a_src);
  end
endmodule // guard_switch_model
`default_nettype wire

// ---- dual_channel_guard_input_monitor_tb.sv ----
// self-checking bench for the guard input monitor
`timescale 1ns/1ns
`default_nettype none
module dual_channel_guard_input_monitor_tb;
  import guard_monitor_pkg::*;
  logic clock = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  logic contact_a, contact_b; // contact levels
  wiring_t wiring = dual_2t; // wiring option
  logic reset_req = 1'b0; // reset request
  logic test_pulse_a, test_pulse_b; // pulse drives
  logic [1:0] safety_output_pair; // safety outputs
  logic reset_blocked, discrepancy_fault, power_short_fault; // status
  logic cross_short_fault, complement_fault, short_detect_active; // status
  logic open_a = 1'b0, open_b = 1'b0, compl = 1'b0; // actuators
  logic short_pwr = 1'b0, short_cross = 1'b0; // injected faults
  int err_total = 0; // mismatches
  int n_compared = 0; // comparisons made
  int cycles = 0; // cycles run, for the hang limit
  // 100 ns clock
  always #50 clock = ~clock;
  // short counts keep the run brief
  guard_input_monitor #(.DEBOUNCE(20), .CROSS_OPEN(50), .PULSE_PERIOD(40), .PULSE_WIDTH(5))
    guard_input_monitor_inst (.clock(clock), .rst_n(rst_n), .contact_a(contact_a),
    .contact_b(contact_b), .wiring(wiring), .reset_req(reset_req),
    .test_pulse_a(test_pulse_a), .test_pulse_b(test_pulse_b),
    .safety_output_pair(safety_output_pair), .reset_blocked(reset_blocked),
    .discrepancy_fault(discrepancy_fault), .power_short_fault(power_short_fault),
    .cross_short_fault(cross_short_fault), .complement_fault(complement_fault),
    .short_detect_active(short_detect_active));
  guard_switch_model guard_switch_model_inst (.test_pulse_a(test_pulse_a),
    .test_pulse_b(test_pulse_b), .open_a(open_a), .open_b(open_b), .compl(compl),
    .short_pwr(short_pwr), .short_cross(short_cross), .contact_a(contact_a),
    .contact_b(contact_b));
  // hang limit, far above the roughly 1,100 cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_pair(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reset with a fresh wiring choice, then let the close filters settle
  task automatic restart(input wiring_t mode, input logic comp);
    rst_n = 1'b0;
    wiring = mode;
    compl = comp;
    open_a = 1'b0;
    open_b = 1'b0;
    short_pwr = 1'b0;
    short_cross = 1'b0;
    tick(6);
    check_pair(safety_output_pair, 2'b00);
    rst_n = 1'b1;
    tick(25);
  endtask
  // one reset request, outputs expected on
  task automatic accept();
    reset_req = 1'b1;
    tick(1);
    reset_req = 1'b0;
    tick(2);
    check_pair(safety_output_pair, 2'b11);
  endtask
  // one channel opens, the other sticks; full cycle of both then clears
  task automatic test_one_channel();
    restart(dual_2t, 1'b0);
    accept();
    open_a = 1'b1;
    tick(30);
    check_pair(safety_output_pair, 2'b00);
    check_bit(reset_blocked, 1'b1);
    open_a = 1'b0;
    tick(25);
    reset_req = 1'b1;
    tick(3);
    check_pair(safety_output_pair, 2'b00);
    check_bit(discrepancy_fault, 1'b1);
    reset_req = 1'b0;
    open_a = 1'b1;
    open_b = 1'b1;
    tick(30);
    open_a = 1'b0;
    open_b = 1'b0;
    tick(40);
    check_bit(discrepancy_fault, 1'b1);
    check_bit(reset_blocked, 1'b0);
    accept();
    check_bit(discrepancy_fault, 1'b0);
  endtask
  // pulsed single channel: clean pulses pass, a short to power trips
  task automatic test_power_short();
    restart(single_2t, 1'b0);
    check_bit(short_detect_active, 1'b1);
    // find the next low pulse on a, then time its width; b is never pulsed here
    repeat (45) begin
      if (test_pulse_a) begin
        tick(1);
      end
    end
    check_bit(test_pulse_a, 1'b0);
    check_bit(test_pulse_b, 1'b1);
    tick(4);
    check_bit(test_pulse_a, 1'b0);
    tick(1);
    check_bit(test_pulse_a, 1'b1);
    accept();
    tick(50);
    check_pair(safety_output_pair, 2'b11);
    short_pwr = 1'b1;
    tick(50);
    check_bit(power_short_fault, 1'b1);
    check_pair(safety_output_pair, 2'b00);
  endtask
  // wirings with and without power short detection
  task automatic test_modes();
    wiring_t modes[5] = '{single_1t, single_pnp, dual_pnp, dual_3t, dual_4t};
    logic detects[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      restart(modes[i], 1'b0);
      check_bit(short_detect_active, detects[i]);
      accept();
      short_pwr = 1'b1;
      tick(50);
      check_bit(power_short_fault, detects[i]);
    end
  endtask
  // four-terminal wiring sees the lines tied together
  task automatic test_cross();
    restart(dual_4t, 1'b0);
    accept();
    short_cross = 1'b1;
    tick(50);
    check_bit(cross_short_fault, 1'b1);
    check_pair(safety_output_pair, 2'b00);
  endtask
  // complementary pairs: a open with b closed runs, equal levels trip late
  task automatic test_compl();
    wiring_t modes[2] = '{compl_2t, compl_x2};
    for (int i = 0; i < 2; i++) begin
      restart(modes[i], 1'b1);
      open_a = 1'b1;
      open_b = 1'b1;
      tick(30);
      open_a = 1'b0;
      open_b = 1'b0;
      tick(30);
      accept();
      open_a = 1'b1;
      tick(5);
      check_bit(complement_fault, 1'b0);
      tick(20);
      check_bit(complement_fault, 1'b0);
      tick(20);
      check_bit(complement_fault, 1'b1);
      check_pair(safety_output_pair, 2'b00);
    end
  endtask
  // report and stop
  task automatic complete_run();
    $display("mismatches %0d of %0d compared", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    test_one_channel();
    test_power_short();
    test_modes();
    test_cross();
    test_compl();
    complete_run();
  end
endmodule // dual_channel_guard_input_monitor_tb
`default_nettype wire
